// File: hdl/fps_cfg.svh
// Purpose: constants of the flash program/erase host controller
// Assumes: 250 MHz clk; times in ns
// Notes:   register offsets, field positions, flash command codes, strobe timing
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// ----------------------------------------------------------------------------
// own registers (byte offsets)
// ----------------------------------------------------------------------------
`define FPS_REG_CTRL       8'h00
`define FPS_REG_ADDR       8'h04
`define FPS_REG_WDATA      8'h08
`define FPS_REG_COUNT      8'h0c
`define FPS_REG_STAT       8'h10
`define FPS_REG_RDATA      8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FPS_CTRL_BYTE      8
`define FPS_CTRL_WP_HIGH   9
`define FPS_CTRL_RP_HIGH   10
`define FPS_STAT_BUSY      16
`define FPS_STAT_REFUSED   17
`define FPS_STAT_STS       18
`define FPS_STAT_ARGERR    19
`define FPS_SR_READY       7
`define FPS_SR_ESUSP       6
`define FPS_SR_EERR        5
`define FPS_SR_WERR        4
`define FPS_XSR_BUFAVL     7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define FPS_RST_BYTE       1'b0
`define FPS_RST_WP_HIGH    1'b0
`define FPS_RST_RP_HIGH    1'b0

// ----------------------------------------------------------------------------
// flash command codes and buffer count limits
// ----------------------------------------------------------------------------
`define FPS_CMD_CHIP_SETUP 8'h30
`define FPS_CMD_CONFIRM    8'hd0
`define FPS_CMD_WRITE      8'h40
`define FPS_CMD_WRITE_ALT  8'h10
`define FPS_CMD_BUF_SETUP  8'he8
`define FPS_CMD_SUSPEND    8'hb0
`define FPS_CMD_RESUME     8'hd0
`define FPS_CMD_CLR_STAT   8'h50
`define FPS_CMD_RD_STAT    8'h70
`define FPS_CMD_RD_ARRAY   8'hff
`define FPS_CNT_MAX_BYTE   5'h1f
`define FPS_CNT_MAX_WORD   5'h0f

// ----------------------------------------------------------------------------
// strobe timing
// ----------------------------------------------------------------------------
`define FPS_CLK_NS         4
`define FPS_T_WP_NS        50
`define FPS_T_WPH_NS       20
`define FPS_T_RD_NS        100
`define FPS_WP_CYC   ((`FPS_T_WP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_WPH_CYC  ((`FPS_T_WPH_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_RD_CYC   ((`FPS_T_RD_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)

`endif

// File: hdl/fps_host.sv
// Purpose: host controller that sequences flash erase/write commands over its pins
// Assumes: apb slave with zero wait states; flash pins sampled through 3 flops
// Notes:   one command at a time; each command but clear, resume and the two reads ends when status is seen ready
`timescale 1ns/10ps
`include "fps_cfg.svh"

module fps_host #(
  parameter int AW        = 21,
  parameter int DW        = 16,
  parameter int BUF_DEPTH = 32
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic      [AW-1:0] f_addr,
  input  wire logic [DW-1:0] f_dq_i,
  output logic      [DW-1:0] f_dq_o,
  output logic               f_dq_oe,
  output logic               f_ce_n,
  output logic               f_oe_n,
  output logic               f_we_n,
  output logic               f_wp_n,
  output logic               f_byte_n,
  output logic               f_rp_n,
  input  wire logic          f_sts
);

  localparam int BIW = $clog2(BUF_DEPTH) + 1;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  fps_pkg::fps_state_t state,    next_state;
  fps_pkg::fps_phase_t phase,    next_phase;
  fps_pkg::fps_op_t    op,       next_op;
  logic [7:0]          tmr,      next_tmr;
  logic [BIW-1:0]      idx,      next_idx;
  logic [BIW-1:0]      widx,     next_widx;
  logic [AW-1:0]       addr_r,   next_addr_r;
  logic [4:0]          count_r,  next_count_r;
  logic                byte_md,  next_byte_md;
  logic                wp_high,  next_wp_high;
  logic                rp_high,  next_rp_high;
  logic [7:0]          fstat,    next_fstat;
  logic [7:0]          fxsr,     next_fxsr;
  logic [DW-1:0]       rdata_r,  next_rdata_r;
  logic                refused,  next_refused;
  logic                arg_err,  next_arg_err;
  logic                chip_run, next_chip_run;
  logic [31:0]         next_prdata;
  logic [AW-1:0]       next_f_addr;
  logic [DW-1:0]       next_f_dq_o;
  logic                next_f_dq_oe;
  logic                next_f_ce_n;
  logic                next_f_oe_n;
  logic                next_f_we_n;
  logic [DW-1:0]       dq_s1, dq_s2, dq_s3;
  logic                sts_s1, sts_s2, sts_s3;
  logic [DW-1:0]       buf_mem [BUF_DEPTH];
  logic                buf_we;
  logic                acc_wr, acc_set, hit, busy;
  fps_pkg::fps_op_t    req_op;
  logic [7:0]          first_cmd;

  // apb decode; every slave answers at once
  assign acc_wr  = psel & penable & pwrite;
  assign acc_set = psel & ~penable;
  assign hit     = (paddr == `FPS_REG_CTRL) | (paddr == `FPS_REG_ADDR) |
                   (paddr == `FPS_REG_WDATA) | (paddr == `FPS_REG_COUNT) |
                   (paddr == `FPS_REG_STAT) | (paddr == `FPS_REG_RDATA);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign busy    = (state != fps_pkg::ST_IDLE);
  assign req_op  = fps_pkg::fps_op_t'(pwdata[3:0]);
  assign f_wp_n   = wp_high;
  assign f_byte_n = ~byte_md;
  assign f_rp_n   = rp_high;

  // first command byte of each operation
  always_comb begin
    unique case (op)
      fps_pkg::OP_CHIP:   first_cmd = `FPS_CMD_CHIP_SETUP;
      fps_pkg::OP_WORD:   first_cmd = `FPS_CMD_WRITE;
      fps_pkg::OP_BUF:    first_cmd = `FPS_CMD_BUF_SETUP;
      fps_pkg::OP_SUSP:   first_cmd = `FPS_CMD_SUSPEND;
      fps_pkg::OP_RESUME: first_cmd = `FPS_CMD_RESUME;
      fps_pkg::OP_CLEAR:  first_cmd = `FPS_CMD_CLR_STAT;
      fps_pkg::OP_RDSTAT: first_cmd = `FPS_CMD_RD_STAT;
      default:            first_cmd = `FPS_CMD_RD_ARRAY;
    endcase
  end

  // ----------------------------------------------------------------------------
  // next-state logic: registers and flash sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_phase    = phase;
    next_op       = op;
    next_tmr      = tmr;
    next_idx      = idx;
    next_widx     = widx;
    next_addr_r   = addr_r;
    next_count_r  = count_r;
    next_byte_md  = byte_md;
    next_wp_high  = wp_high;
    next_rp_high  = rp_high;
    next_fstat    = fstat;
    next_fxsr     = fxsr;
    next_rdata_r  = rdata_r;
    next_refused  = refused;
    next_arg_err  = arg_err;
    next_chip_run = chip_run;
    next_prdata   = prdata;
    next_f_addr   = f_addr;
    next_f_dq_o   = f_dq_o;
    next_f_dq_oe  = f_dq_oe;
    next_f_ce_n   = f_ce_n;
    next_f_oe_n   = f_oe_n;
    next_f_we_n   = f_we_n;
    buf_we        = 1'b0;

    // register read data, prepared in the setup cycle
    if (acc_set) begin
      unique case (paddr)
        `FPS_REG_CTRL:  next_prdata = {21'h0, rp_high, wp_high, byte_md, 4'h0, op};
        `FPS_REG_ADDR:  next_prdata = 32'(addr_r);
        `FPS_REG_COUNT: next_prdata = {27'h0, count_r};
        `FPS_REG_STAT:  next_prdata = {12'h0, arg_err, sts_s3, refused, busy,
                                       fxsr, fstat};
        `FPS_REG_RDATA: next_prdata = 32'(rdata_r);
        default:        next_prdata = 32'h0;
      endcase
    end

    // register writes
    if (acc_wr) begin
      unique case (paddr)
        `FPS_REG_ADDR:  next_addr_r = pwdata[AW-1:0];
        `FPS_REG_COUNT: begin
          next_count_r = pwdata[4:0];
          next_widx    = '0;
        end
        `FPS_REG_WDATA: begin
          if (widx < BIW'(BUF_DEPTH)) begin
            buf_we    = 1'b1;
            next_widx = widx + 1'b1;
          end
        end
        `FPS_REG_CTRL: begin
          next_byte_md = pwdata[`FPS_CTRL_BYTE];
          next_wp_high = pwdata[`FPS_CTRL_WP_HIGH];
          next_rp_high = pwdata[`FPS_CTRL_RP_HIGH];
          if (req_op != fps_pkg::OP_NONE) begin
            next_refused = 1'b0;
            next_arg_err = 1'b0;
            if (busy || req_op > fps_pkg::OP_RDARR) begin
              next_refused = 1'b1;
            end else if (req_op == fps_pkg::OP_BUF &&
                         (fstat[`FPS_SR_WERR] | fstat[`FPS_SR_EERR])) begin
              next_refused = 1'b1;
            end else if (req_op == fps_pkg::OP_BUF && !byte_md &&
                         count_r > `FPS_CNT_MAX_WORD) begin
              next_arg_err = 1'b1;
            end else if (req_op == fps_pkg::OP_SUSP && chip_run) begin
              next_refused = 1'b1;
            end else if (req_op == fps_pkg::OP_CHIP && fstat[`FPS_SR_ESUSP]) begin
              next_refused = 1'b1;
            end else begin
              next_op       = req_op;
              next_phase    = fps_pkg::PH_C1;
              next_idx      = '0;
              next_state    = fps_pkg::ST_DECIDE;
              next_chip_run = (req_op == fps_pkg::OP_CHIP);
            end
          end
        end
        default: ;
      endcase
    end

    // flash sequencer
    unique case (state)
      fps_pkg::ST_IDLE: ;
      fps_pkg::ST_DECIDE: begin
        next_f_addr = addr_r;
        next_f_dq_o = DW'(first_cmd);
        next_tmr    = 8'(`FPS_WP_CYC - 1);
        next_state  = fps_pkg::ST_WLOW;
        unique case (phase)
          fps_pkg::PH_C1: begin
            unique case (op)
              fps_pkg::OP_CHIP, fps_pkg::OP_WORD: next_phase = fps_pkg::PH_C2;
              fps_pkg::OP_BUF:                    next_phase = fps_pkg::PH_XSR;
              fps_pkg::OP_SUSP:                   next_phase = fps_pkg::PH_POLL;
              fps_pkg::OP_RDSTAT, fps_pkg::OP_RDARR: next_phase = fps_pkg::PH_POLL;
              default:                            next_phase = fps_pkg::PH_DONE;
            endcase
          end
          fps_pkg::PH_C2: begin
            next_f_dq_o = (op == fps_pkg::OP_CHIP) ? DW'(`FPS_CMD_CONFIRM)
                                                   : buf_mem[0];
            next_phase  = fps_pkg::PH_POLL;
          end
          fps_pkg::PH_CNT: begin
            next_f_dq_o = DW'(count_r);
            next_phase  = fps_pkg::PH_DAT;
          end
          fps_pkg::PH_DAT: begin
            next_f_addr = addr_r + AW'(idx);
            next_f_dq_o = buf_mem[idx[BIW-2:0]];
            next_idx    = idx + 1'b1;
            if (idx == {1'b0, count_r}) begin
              next_phase = fps_pkg::PH_CONF;
            end
          end
          fps_pkg::PH_CONF: begin
            next_f_dq_o = DW'(`FPS_CMD_CONFIRM);
            next_phase  = fps_pkg::PH_POLL;
          end
          fps_pkg::PH_XCHK: begin
            next_state = fps_pkg::ST_DECIDE;
            next_phase = fxsr[`FPS_XSR_BUFAVL] ? fps_pkg::PH_CNT
                                               : fps_pkg::PH_C1;
          end
          fps_pkg::PH_PCHK: begin
            next_state = fps_pkg::ST_DECIDE;
            next_phase = fstat[`FPS_SR_READY] ? fps_pkg::PH_DONE
                                              : fps_pkg::PH_POLL;
          end
          fps_pkg::PH_DONE: begin
            next_state    = fps_pkg::ST_IDLE;
            next_chip_run = 1'b0;
          end
          default: begin
            // status or array read cycle
            next_tmr   = 8'(`FPS_RD_CYC - 1);
            next_state = fps_pkg::ST_RWAIT;
            next_f_oe_n = 1'b0;
            next_phase = (phase == fps_pkg::PH_XSR) ? fps_pkg::PH_XCHK :
                         (phase == fps_pkg::PH_POLL && op != fps_pkg::OP_RDSTAT &&
                          op != fps_pkg::OP_RDARR) ? fps_pkg::PH_PCHK
                                                   : fps_pkg::PH_DONE;
          end
        endcase
        next_f_ce_n = (next_state != fps_pkg::ST_WLOW) && (next_state != fps_pkg::ST_RWAIT);
        next_f_we_n = ~(next_state == fps_pkg::ST_WLOW);
        next_f_dq_oe = (next_state == fps_pkg::ST_WLOW);
      end
      fps_pkg::ST_WLOW: begin
        // strobe low, then high; device latches on the rising edge
        if (tmr != 8'h00) begin
          next_tmr = tmr - 1'b1;
        end else if (!f_we_n) begin
          next_f_we_n = 1'b1;
          next_tmr    = 8'(`FPS_WPH_CYC - 1);
        end else begin
          next_f_dq_oe = 1'b0;
          next_f_ce_n  = 1'b1;
          next_state   = fps_pkg::ST_DECIDE;
        end
      end
      fps_pkg::ST_RWAIT: begin
        // take read data once two sampled copies agree
        if (tmr != 8'h00) begin
          next_tmr = tmr - 1'b1;
        end else if (dq_s2 == dq_s3) begin
          next_rdata_r = dq_s3;
          if (phase == fps_pkg::PH_XCHK) begin
            next_fxsr = dq_s3[7:0];
          end else if (op != fps_pkg::OP_RDARR) begin
            next_fstat = dq_s3[7:0];
          end
          next_f_oe_n = 1'b1;
          next_f_ce_n = 1'b1;
          next_state  = fps_pkg::ST_DECIDE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= fps_pkg::ST_IDLE;
      phase    <= fps_pkg::PH_DONE;
      op       <= fps_pkg::OP_NONE;
      tmr      <= 8'h00;
      idx      <= '0;
      widx     <= '0;
      addr_r   <= '0;
      count_r  <= 5'h00;
      byte_md  <= `FPS_RST_BYTE;
      wp_high  <= `FPS_RST_WP_HIGH;
      rp_high  <= `FPS_RST_RP_HIGH;
      fstat    <= 8'h00;
      fxsr     <= 8'h00;
      rdata_r  <= '0;
      refused  <= 1'b0;
      arg_err  <= 1'b0;
      chip_run <= 1'b0;
      prdata   <= 32'h0;
      f_addr   <= '0;
      f_dq_o   <= '0;
      f_dq_oe  <= 1'b0;
      f_ce_n   <= 1'b1;
      f_oe_n   <= 1'b1;
      f_we_n   <= 1'b1;
      dq_s1    <= '0;
      dq_s2    <= '0;
      dq_s3    <= '0;
      sts_s1   <= 1'b0;
      sts_s2   <= 1'b0;
      sts_s3   <= 1'b0;
    end else begin
      state    <= next_state;
      phase    <= next_phase;
      op       <= next_op;
      tmr      <= next_tmr;
      idx      <= next_idx;
      widx     <= next_widx;
      addr_r   <= next_addr_r;
      count_r  <= next_count_r;
      byte_md  <= next_byte_md;
      wp_high  <= next_wp_high;
      rp_high  <= next_rp_high;
      fstat    <= next_fstat;
      fxsr     <= next_fxsr;
      rdata_r  <= next_rdata_r;
      refused  <= next_refused;
      arg_err  <= next_arg_err;
      chip_run <= next_chip_run;
      prdata   <= next_prdata;
      f_addr   <= next_f_addr;
      f_dq_o   <= next_f_dq_o;
      f_dq_oe  <= next_f_dq_oe;
      f_ce_n   <= next_f_ce_n;
      f_oe_n   <= next_f_oe_n;
      f_we_n   <= next_f_we_n;
      dq_s1    <= f_dq_i;
      dq_s2    <= dq_s1;
      dq_s3    <= dq_s2;
      sts_s1   <= f_sts;
      sts_s2   <= sts_s1;
      sts_s3   <= sts_s2;
    end
  end

  // buffer for buffered-write data, filled through the data register
  always_ff @(posedge clk) begin
    if (buf_we) begin
      buf_mem[widx[BIW-2:0]] <= pwdata[DW-1:0];
    end
  end

endmodule

// File: hdl/fps_pkg.sv
// Purpose: types of the flash program/erase host controller
// Assumes: one-hot state codes
// Notes:   constants live in fps_cfg.svh
package fps_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DECIDE = 4'b0010,
    ST_WLOW   = 4'b0100,
    ST_RWAIT  = 4'b1000
  } fps_state_t;

  typedef enum logic [9:0] {
    PH_C1   = 10'b0000000001,
    PH_C2   = 10'b0000000010,
    PH_XSR  = 10'b0000000100,
    PH_XCHK = 10'b0000001000,
    PH_CNT  = 10'b0000010000,
    PH_DAT  = 10'b0000100000,
    PH_CONF = 10'b0001000000,
    PH_POLL = 10'b0010000000,
    PH_PCHK = 10'b0100000000,
    PH_DONE = 10'b1000000000
  } fps_phase_t;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_CHIP   = 4'h1,
    OP_WORD   = 4'h2,
    OP_BUF    = 4'h3,
    OP_SUSP   = 4'h4,
    OP_RESUME = 4'h5,
    OP_CLEAR  = 4'h6,
    OP_RDSTAT = 4'h7,
    OP_RDARR  = 4'h8
  } fps_op_t;

endpackage

// File: test/fps_flash_model.sv
// Purpose: behavioural flash device behind the host pins
// Assumes: commands latch on the rising edge of we_n
// Notes:   busy lasts BUSY clk cycles; released data shows the inverse
`timescale 1ns/10ps
module fps_flash_model #(
  parameter int          BUSY       = 60,
  parameter int          ERASE_FAIL = 0,
  parameter logic [15:0] STUCK      = 16'h0000
) (
  input  wire logic        clk,
  input  wire logic [20:0] f_addr,
  input  wire logic [15:0] f_dq_o,
  input  wire logic        f_ce_n,
  input  wire logic        f_oe_n,
  input  wire logic        f_we_n,
  input  wire logic        vpp_low,
  output logic      [15:0] f_dq_i,
  output logic             f_sts
);
  logic [7:0]  sr = 8'h00;
  logic [7:0]  c;
  logic [1:0]  mode = 2'd1;
  logic [15:0] wdat;
  logic [15:0] last = 16'h0000;
  logic [15:0] rdv;
  logic [5:0]  blk = 6'h00;
  logic        rdy = 1'b1;
  time         done_at = 0;
  int          ph = 0;
  int          left = 0;
  int          nwords = 0;
  // ready level; pulled up while idle
  always @(posedge clk) rdy <= ($time >= done_at);
  assign f_sts = rdy;
  // array, extended status or status on reads
  assign rdv = (mode == 2'd0) ? ~f_addr[15:0] :
               (mode == 2'd2) ? {8'h00, ~(sr[5] | sr[4]), 7'h00} :
               {8'h00, rdy, sr[6:0]};
  assign f_dq_i = (!f_oe_n && !f_ce_n) ? rdv : ~last;
  always @(posedge f_oe_n) last <= rdv;
  // command interface
  always @(posedge f_we_n) begin
    if (!f_ce_n) begin
      c = f_dq_o[7:0];
      mode = 2'd1;
      case (ph)
        1: begin
          ph = 0;
          if (c != 8'hd0) sr[5:4] = 2'b11;
          else if (vpp_low) sr = sr | 8'h28;
          else if (ERASE_FAIL != 0) sr[5] = 1'b1;
          else done_at = $time + BUSY * 4;
        end
        2: begin
          ph = 0;
          wdat = f_dq_o;
          if (vpp_low) sr = sr | 8'h18;
          else if ((~f_dq_o & STUCK) != 16'h0000) sr[4] = 1'b1;
          else done_at = $time + BUSY * 4;
        end
        3: begin
          left = c + 1;
          blk = f_addr[20:15];
          ph = 4;
        end
        4: begin
          if (f_addr[20:15] != blk) sr[5:4] = 2'b11;
          nwords++;
          left--;
          if (left == 0) ph = 5;
        end
        5: begin
          ph = 0;
          if (c != 8'hd0) sr[5:4] = 2'b11;
          else if (vpp_low) sr = sr | 8'h18;
          else done_at = $time + BUSY * 4;
        end
        default: case (c)
          8'h30: begin
            if (sr[6]) sr[5:4] = 2'b11;
            else ph = 1;
          end
          8'h40, 8'h10: ph = 2;
          8'he8: begin
            mode = 2'd2;
            if (!(sr[5] | sr[4])) ph = 3;
          end
          8'hb0: if (rdy) sr[6] = 1'b1;
          8'hd0: sr[6] = 1'b0;
          8'h50: sr[5:1] = 5'h00;
          8'h70: mode = 2'd1;
          8'hff: mode = 2'd0;
          default: sr[5:4] = 2'b11;
        endcase
      endcase
    end
  end
endmodule

// File: test/fps_host_assertions.sv
// Purpose: timing checks on the flash host pins and apb answers
// Assumes: one clock, async active-low reset
// Notes:   strobe widths follow the fixed write and read timing
`timescale 1ns/10ps
module fps_host_assertions #(
  parameter int AW = 21,
  parameter int DW = 16
) (
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [7:0]    paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [AW-1:0] f_addr,
  input wire logic [DW-1:0] f_dq_o,
  input wire logic          f_dq_oe,
  input wire logic          f_ce_n,
  input wire logic          f_oe_n,
  input wire logic          f_we_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic unmapped;
  // addresses outside the six aligned words
  assign unmapped = (paddr > 8'h14) || (paddr[1:0] != 2'b00);
  sequence s_we_low;
    (!f_we_n)[*8] ##1 (!f_we_n)[*5];
  endsequence
  sequence s_rd_low;
    (!f_oe_n)[*8] ##1 (!f_oe_n)[*8] ##1 (!f_oe_n)[*8] ##1 !f_oe_n;
  endsequence
  a_pready_high: assert property (pready) else $error("pready low");
  a_slverr_unmapped: assert property (psel && penable |-> pslverr == unmapped)
    else $error("pslverr wrong");
  a_we_in_ce: assert property (!f_we_n |-> !f_ce_n && f_dq_oe && f_oe_n)
    else $error("strobe outside cycle");
  a_we_low_width: assert property ($fell(f_we_n) |-> s_we_low ##1 f_we_n)
    else $error("we_n low width");
  a_we_gap_width: assert property ($rose(f_we_n) |-> (!f_ce_n)[*5] ##1 f_ce_n)
    else $error("we_n high hold");
  a_latch_stable: assert property ($rose(f_we_n) |-> $stable(f_dq_o) && $stable(f_addr))
    else $error("data moved at latch");
  a_read_width: assert property ($fell(f_oe_n) |-> s_rd_low)
    else $error("oe_n low width");
  a_read_no_drive: assert property (!f_oe_n |-> !f_dq_oe && f_we_n && !f_ce_n)
    else $error("drive during read");
endmodule
bind fps_host fps_host_assertions #(.AW(AW), .DW(DW)) u_chk (
  .clk, .arst_n, .psel, .penable, .paddr, .pready, .pslverr,
  .f_addr, .f_dq_o, .f_dq_oe, .f_ce_n, .f_oe_n, .f_we_n
);

// File: test/tb_fps_host.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: 250 MHz clk; apb driven on rising edges
// Notes:   table rows run one operation each, odd cases follow
`timescale 1ns/10ps
module tb_fps_host;
  typedef struct packed {
    logic [3:0] op;
    logic       vpp;
    logic [4:0] cnt;
    logic [7:0] sr;
    logic       rf;
  } fps_row_t;
  logic        clk = 1'b0;
  logic        arst_n, psel, penable, pwrite, pready, pslverr, vpp_low;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] f_addr;
  logic [15:0] f_dq_i, f_dq_o;
  logic        f_dq_oe, f_ce_n, f_oe_n, f_we_n, f_wp_n, f_byte_n, f_rp_n, f_sts, err;
  int          mismatches = 0;
  int          comparisons = 0;
  fps_row_t    rows [15] = '{
    '{4'h7, 1'b0, 5'h00, 8'h80, 1'b0}, '{4'h1, 1'b0, 5'h00, 8'h80, 1'b0},
    '{4'h2, 1'b0, 5'h00, 8'h80, 1'b0}, '{4'h1, 1'b1, 5'h00, 8'ha8, 1'b0},
    '{4'h6, 1'b0, 5'h00, 8'ha8, 1'b0}, '{4'h2, 1'b1, 5'h00, 8'h98, 1'b0},
    '{4'h3, 1'b0, 5'h02, 8'h98, 1'b1}, '{4'h6, 1'b0, 5'h00, 8'h98, 1'b0},
    '{4'h7, 1'b0, 5'h00, 8'h80, 1'b0}, '{4'h3, 1'b0, 5'h02, 8'h80, 1'b0},
    '{4'h4, 1'b0, 5'h00, 8'hc0, 1'b0}, '{4'h1, 1'b0, 5'h00, 8'hc0, 1'b1},
    '{4'h5, 1'b0, 5'h00, 8'hc0, 1'b0}, '{4'h7, 1'b0, 5'h00, 8'h80, 1'b0},
    '{4'h8, 1'b0, 5'h00, 8'h80, 1'b0}};
  always #2 clk = ~clk;
  fps_host u_dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .f_addr, .f_dq_i, .f_dq_o, .f_dq_oe, .f_ce_n, .f_oe_n,
    .f_we_n, .f_wp_n, .f_byte_n, .f_rp_n, .f_sts);
  fps_flash_model u_flash (.clk, .f_addr, .f_dq_o, .f_ce_n, .f_oe_n, .f_we_n,
    .vpp_low, .f_dq_i, .f_sts);
  // compare and count
  task chk(input logic ok, input string m);
    comparisons++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // one apb transfer; answer taken at the edge with pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll the busy bit
  task wait_idle;
    int k;
    k = 0;
    apb(1'b0, 8'h10, 32'h0);
    while (rd[16] !== 1'b0 && k < 3000) begin
      apb(1'b0, 8'h10, 32'h0);
      k++;
    end
    if (k >= 3000) chk(1'b0, "busy timeout");
  endtask
  task wrap_up;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, vpp_low} = '0;
    repeat (3) @(posedge clk);
    chk(f_rp_n === 1'b0 && f_we_n === 1'b1 && f_dq_oe === 1'b0 && f_wp_n === 1'b0 &&
        f_byte_n === 1'b1, "reset pins");
    arst_n <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      vpp_low <= rows[i].vpp;
      apb(1'b1, 8'h0c, {27'h0, rows[i].cnt});
      for (int j = 0; j <= rows[i].cnt; j++) apb(1'b1, 8'h08, 32'h1230 + i);
      apb(1'b1, 8'h04, 32'h100 + 16 * i);
      apb(1'b1, 8'h00, {28'h040, rows[i].op});
      wait_idle();
      chk(rd[7:0] === rows[i].sr && rd[17] === rows[i].rf, "row status");
      chk(rd[18] === 1'b1 && f_ce_n === 1'b1, "sts idle, ce high");
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(rd[15:0] === 16'hfe1f, "array read");
    chk(u_flash.wdat === 16'h1235 && u_flash.nwords == 3, "data at flash");
    apb(1'b0, 8'h20, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h00, 32'h403);
    wait_idle();
    chk(rd[19] === 1'b1 && u_flash.nwords == 3, "word count limit");
    apb(1'b1, 8'h00, 32'h401);
    apb(1'b1, 8'h00, 32'h404);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[17] === 1'b1 && rd[16] === 1'b1, "suspend refused");
    wait_idle();
    chk(u_flash.sr[6] === 1'b0, "no suspend at flash");
    apb(1'b1, 8'h00, 32'h709);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[17] === 1'b1 && f_byte_n === 1'b0 && f_wp_n === 1'b1 && f_rp_n === 1'b1,
        "illegal op, ctrl pins");
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(f_rp_n === 1'b0 && f_ce_n === 1'b1 && f_oe_n === 1'b1 && f_dq_oe === 1'b0,
        "mid reset pins");
    arst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[10:8] === 3'b000, "ctrl after reset");
    wrap_up();
  end
endmodule
